// [hw/ledpwm_pkg.sv]
// shared constants and types for the led pwm intensity and blink block
package ledpwm_pkg;

  localparam int          NUM_PORTS      = 16;
  localparam int          NUM_OUTS       = 17;
  localparam int          CODE_W         = 4;

  // register address codes
  localparam logic [7:0]  ADDR_PH1_LOW   = 8'h0A;
  localparam logic [7:0]  ADDR_PH1_HIGH  = 8'h0B;
  localparam logic [7:0]  ADDR_MASTER    = 8'h0E;

  localparam logic [7:0]  PH1_RESET      = 8'h00;
  localparam logic [7:0]  MASTER_RESET   = 8'h00;

  localparam logic [3:0]  CODE_STATIC    = 4'hF;
  localparam logic [3:0]  MASTER_OFF     = 4'h0;
  localparam logic [3:0]  LAST_SLOT      = 4'hE;
  localparam logic [3:0]  LAST_CYCLE     = 4'hF;
  localparam logic [3:0]  ZERO_NIB       = 4'h0;

  // field positions in the master register
  localparam int          MASTER_HI      = 7;
  localparam int          MASTER_LO      = 4;
  localparam int          LAST_HI        = 3;
  localparam int          LAST_LO        = 0;

  // step rate from the nominal 32 kHz oscillator
  localparam int          OSC_PERIOD_NS  = 31250;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          STEP_DIV_CYC   = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          DIV_W          = 16;

  typedef struct packed {
    logic global_en;
    logic blink_en;
    logic flip_flag;
  } ledpwm_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } ledpwm_req_t;

endpackage

// [hw/ledpwm_cell.sv]
// one output's pwm level decision
`timescale 1ns/10ps
`default_nettype none
module ledpwm_cell
  import ledpwm_pkg::*;
(
  // timing
  input  wire logic        all_static,
  input  wire logic        slot_en,
  input  wire logic [3:0]  cyc,
  // setting
  input  wire logic [3:0]  code,
  input  wire logic        level,
  // result
  output logic             want
);

  always_comb begin
    if (all_static || code == CODE_STATIC) begin
      want = level;
    end else if (slot_en && cyc <= code) begin
      want = level;
    end else begin
      // off-time is the inverse level, so level one inverts the duty
      want = ~level;
    end
  end

endmodule
`default_nettype wire

// [hw/ledpwm_top.sv]
// led pwm intensity and two-phase blink output logic
`timescale 1ns/10ps
`default_nettype none
module ledpwm_top
  import ledpwm_pkg::*;
#(
  parameter int STEP_DIV = STEP_DIV_CYC
)
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // register access
  input  wire ledpwm_req_t           req,
  output logic [7:0]                 reg_rdata,
  // other control state
  input  wire ledpwm_cfg_t           cfg,
  input  wire logic [NUM_PORTS-1:0]  phase0_bits,
  input  wire logic [1:0]            last_out_phase_bits,
  input  wire logic [63:0]           port_codes,
  input  wire logic                  blink_pin,
  // open-drain outputs
  output logic [NUM_OUTS-1:0]        ports_out,
  output logic [NUM_OUTS-1:0]        ports_oe
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NUM_PORTS-1:0] phase1;
    logic [7:0]           master;
    logic [DIV_W-1:0]     div;
    logic [3:0]           slot;
    logic [3:0]           cyc;
    logic [1:0]           pin_sync;
    logic [NUM_OUTS-1:0]  level;
    logic [7:0]           rdata;
  } ledpwm_state_t;

  ledpwm_state_t st_reg;
  ledpwm_state_t st_next;

  logic [3:0]           master_code;
  logic                 all_static;
  logic                 tick;
  logic                 slot_en;
  logic                 phase;
  logic [NUM_OUTS-1:0]  phase0_all;
  logic [NUM_OUTS-1:0]  phase1_all;
  logic [NUM_OUTS-1:0]  sel;
  logic [NUM_OUTS-1:0]  want;

  assign master_code = st_reg.master[MASTER_HI:MASTER_LO];
  assign all_static  = (master_code == MASTER_OFF);
  assign tick        = ~all_static && (st_reg.div == DIV_W'(STEP_DIV - 1));
  assign slot_en     = (st_reg.slot < master_code);
  assign phase       = cfg.blink_en & (cfg.flip_flag ^ st_reg.pin_sync[1]);
  assign phase0_all  = {last_out_phase_bits[0], phase0_bits};
  assign phase1_all  = {last_out_phase_bits[1], st_reg.phase1};
  assign sel         = phase ? phase1_all : phase0_all;

  // ****************************************
  // per-output cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTS; gi++) begin : g_cell
      logic [3:0] code;
      if (gi == NUM_OUTS - 1) begin : g_last
        assign code = st_reg.master[LAST_HI:LAST_LO];
      end else begin : g_port
        // global mode ignores the individual codes entirely
        assign code = cfg.global_en ? st_reg.master[LAST_HI:LAST_LO]
                                    : port_codes[gi*CODE_W +: CODE_W];
      end
      ledpwm_cell u_cell (
        .all_static (all_static),
        .slot_en    (slot_en),
        .cyc        (st_reg.cyc),
        .code       (code),
        .level      (sel[gi]),
        .want       (want[gi])
      );
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next          = st_reg;
    st_next.pin_sync = {st_reg.pin_sync[0], blink_pin};
    if (req.wr) begin
      case (req.addr)
        ADDR_PH1_LOW:  st_next.phase1[7:0]  = req.wdata;
        ADDR_PH1_HIGH: st_next.phase1[15:8] = req.wdata;
        ADDR_MASTER:   st_next.master       = req.wdata;
        default:       st_next.master       = st_reg.master;
      endcase
    end
    case (req.addr)
      ADDR_PH1_LOW:  st_next.rdata = st_reg.phase1[7:0];
      ADDR_PH1_HIGH: st_next.rdata = st_reg.phase1[15:8];
      ADDR_MASTER:   st_next.rdata = st_reg.master;
      default:       st_next.rdata = 8'h00;
    endcase
    if (all_static) begin
      // oscillator off: clear the step counters, outputs follow levels directly
      st_next.div   = '0;
      st_next.slot  = ZERO_NIB;
      st_next.cyc   = ZERO_NIB;
      st_next.level = sel;
    end else if (tick) begin
      st_next.div   = '0;
      st_next.level = want;
      if (st_reg.cyc == LAST_CYCLE) begin
        st_next.cyc  = ZERO_NIB;
        st_next.slot = (st_reg.slot == LAST_SLOT) ? ZERO_NIB : st_reg.slot + 4'h1;
      end else begin
        st_next.cyc  = st_reg.cyc + 4'h1;
      end
    end else begin
      st_next.div = st_reg.div + DIV_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.phase1 <= {PH1_RESET, PH1_RESET};
      st_reg.master <= MASTER_RESET;
      st_reg.level  <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign ports_out = '0;
  assign ports_oe  = ~st_reg.level;

  // ****************************************
  // checks
  // ****************************************
  sequence seq_step_end;
    tick && st_reg.cyc == LAST_CYCLE && st_reg.slot == LAST_SLOT;
  endsequence

  sequence seq_write_low;
    req.wr && req.addr == ADDR_PH1_LOW;
  endsequence

  sequence seq_write_high;
    req.wr && req.addr == ADDR_PH1_HIGH;
  endsequence

  ph1_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
    seq_write_low ##1 (!req.wr && req.addr == ADDR_PH1_LOW)
    |=> reg_rdata == $past(req.wdata, 2))
    else $error("phase 1 low readback wrong");

  ph1_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    seq_write_high ##1 (!req.wr && req.addr == ADDR_PH1_HIGH)
    |=> reg_rdata == $past(req.wdata, 2))
    else $error("phase 1 high readback wrong");

  period_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    seq_step_end |=> st_reg.slot == ZERO_NIB && st_reg.cyc == ZERO_NIB)
    else $error("pwm period does not wrap after 240 steps");

  static_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n && all_static ##1 all_static |-> ports_oe == ~$past(sel) && st_reg.div == '0)
    else $error("static mode output or counter wrong");

  full_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && !cfg.global_en && port_codes[3:0] == CODE_STATIC |=> ports_oe[0] == ~$past(sel[0]))
    else $error("code F not static");

  global_all_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && cfg.global_en && st_reg.master[LAST_HI:LAST_LO] == CODE_STATIC
    |=> ports_oe == ~$past(sel))
    else $error("global static not applied to all");

  global_on_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && cfg.global_en && slot_en && st_reg.cyc <= st_reg.master[LAST_HI:LAST_LO]
    |=> ports_oe == ~$past(sel))
    else $error("global on-time not applied to all");

  global_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && cfg.global_en && !slot_en && st_reg.master[LAST_HI:LAST_LO] != CODE_STATIC
    |=> ports_oe == $past(sel))
    else $error("global output active outside master slots");

  last_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && !cfg.global_en && !slot_en && st_reg.master[LAST_HI:LAST_LO] != CODE_STATIC
    |=> ports_oe[NUM_OUTS-1] == $past(sel[NUM_OUTS-1]))
    else $error("seventeenth output active outside master slots");

  gate_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && !slot_en && !cfg.global_en && port_codes[3:0] != CODE_STATIC
    |=> ports_oe[0] == $past(sel[0]))
    else $error("output active outside master slots");

  on_time_a: assert property (@(posedge clock) disable iff (!rst_n)
    tick && slot_en && !cfg.global_en && st_reg.cyc <= port_codes[3:0]
    |=> ports_oe[0] == ~$past(sel[0]))
    else $error("on-time level wrong");

  phase_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!cfg.blink_en |-> sel == phase0_all) and
    (cfg.blink_en && $past(rst_n) && $past(rst_n, 2)
     |-> phase == (cfg.flip_flag ^ $past(blink_pin, 2))))
    else $error("blink phase selection wrong");

  step_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    !all_static && !tick ##1 !all_static |-> $stable(ports_oe))
    else $error("output changed off a step boundary");

endmodule
`default_nettype wire

// [verification/ledpwm_load.sv]
// led loads on the open-drain ports, pulled up when released
`timescale 1ns/10ps
`default_nettype none
module ledpwm_load
  import ledpwm_pkg::*;
(
  // design side
  input  wire logic [NUM_OUTS-1:0] ports_out,
  input  wire logic [NUM_OUTS-1:0] ports_oe,
  // pin side
  output logic      [NUM_OUTS-1:0] pin_level
);
  // a released pin floats up through the load, a driven pin sinks low
  assign pin_level = (ports_oe & ports_out) | ~ports_oe;
endmodule
`default_nettype wire

// [verification/ledpwm_top_tb.sv]
// self-checking bench for the led pwm intensity and blink block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ledpwm_top_tb;
  import ledpwm_pkg::*;
  typedef struct {logic [7:0] mreg; logic glb; logic [3:0] code; logic lvl; int exp;} ledpwm_row_t;
  logic                clock;
  logic                rst_n;
  logic                blink_pin;
  ledpwm_req_t         req;
  ledpwm_cfg_t         cfg;
  logic [15:0]         phase0_bits;
  logic [1:0]          last_out_phase_bits;
  logic [63:0]         port_codes;
  logic [7:0]          reg_rdata;
  logic [16:0]         ports_out;
  logic [16:0]         ports_oe;
  logic [16:0]         pin_level;
  int                  miscompares;
  int                  n_tests;
  int                  cnt;
  // master reg, global flag, port code, level bit, pull-low clocks per 960-clock period
  ledpwm_row_t rows[7] = '{
    '{8'h10, 1'b0, 4'h0, 1'b0, 4},
    '{8'hF0, 1'b0, 4'hE, 1'b0, 900},
    '{8'h30, 1'b0, 4'h7, 1'b1, 864},
    '{8'h52, 1'b1, 4'hF, 1'b0, 60},
    '{8'h20, 1'b0, 4'hF, 1'b0, 960},
    '{8'h0F, 1'b1, 4'h0, 1'b0, 960},
    '{8'h7F, 1'b1, 4'h0, 1'b0, 960}
  };

  ledpwm_top #(.STEP_DIV(4)) i_ledpwm_top (.clock(clock), .rst_n(rst_n), .req(req), .reg_rdata(reg_rdata),
    .cfg(cfg), .phase0_bits(phase0_bits), .last_out_phase_bits(last_out_phase_bits),
    .port_codes(port_codes), .blink_pin(blink_pin), .ports_out(ports_out), .ports_oe(ports_oe));
  ledpwm_load i_ledpwm_load (.ports_out(ports_out), .ports_oe(ports_oe), .pin_level(pin_level));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{a, d, 1'b1};
    @(posedge clock) req.wr <= 1'b0;
  endtask

  // read data lands one cycle after the address is seen
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) req.addr <= a;
    repeat (2) @(posedge clock);
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask

  // static mode answers within a few cycles, blink pin synchroniser included
  task automatic pins(input logic [16:0] e);
    repeat (5) @(posedge clock);
    #1 `CHK("pin_level", e, pin_level)
    @(posedge clock);
  endtask

  initial begin
    #200_000;
    miscompares++;
    end_of_test();
  end

  initial begin
    // ****************************************
    // reset, registers, duty rows, blink
    // ****************************************
    miscompares = 0;
    n_tests = 0;
    rst_n = 1'b0;
    blink_pin = 1'b0;
    req = '{8'h00, 8'h00, 1'b0};
    cfg = '{1'b0, 1'b0, 1'b0};
    phase0_bits = 16'h0000;
    last_out_phase_bits = 2'b00;
    port_codes = '0;
    repeat (12) @(posedge clock);
    #1 `CHK("ports_oe", 17'h0_0000, ports_oe)
    @(posedge clock) rst_n <= 1'b1;
    rd(ADDR_MASTER, MASTER_RESET);
    wr(ADDR_PH1_LOW, 8'h5A);
    wr(ADDR_PH1_HIGH, 8'hA5);
    wr(8'h0C, 8'hFF);
    rd(ADDR_PH1_LOW, 8'h5A);
    rd(ADDR_PH1_HIGH, 8'hA5);
    rd(8'h0C, 8'h00);
    foreach (rows[i]) begin
      wr(ADDR_MASTER, rows[i].mreg);
      cfg.global_en <= rows[i].glb;
      port_codes <= {16{rows[i].code}};
      phase0_bits[0] <= rows[i].lvl;
      repeat (1000) @(posedge clock);
      cnt = 0;
      repeat (960) begin
        @(posedge clock);
        #1 cnt += int'(ports_oe[0]);
      end
      `CHK("oe_count", rows[i].exp, cnt)
    end
    rd(ADDR_MASTER, 8'h7F);
    wr(ADDR_MASTER, 8'h00);
    wr(ADDR_PH1_LOW, 8'h96);
    wr(ADDR_PH1_HIGH, 8'h3C);
    phase0_bits <= 16'hA5C3;
    cfg <= '{1'b0, 1'b0, 1'b1};
    last_out_phase_bits <= 2'b10;
    pins(17'h0_A5C3);
    cfg.blink_en <= 1'b1;
    pins(17'h1_3C96);
    blink_pin <= 1'b1;
    pins(17'h0_A5C3);
    cfg.flip_flag <= 1'b0;
    pins(17'h1_3C96);
    end_of_test();
  end
endmodule
`default_nettype wire
